//--- edr_pkg.sv
// Constants, types and factory data for the display-identification emulation router
package edr_pkg;
  localparam int NUM_IN = 4;
  localparam int NUM_OUT = 2;
  localparam int NUM_FAC = 2;
  localparam int NUM_USER = 2;
  localparam int IN_W = 2;
  localparam int SRC_W = 2;
  localparam int BLK_BYTES = 128;
  localparam int EMU_BYTES = 256;
  localparam int CLK_MHZ = 250;
  localparam int HPD_TIME_MS = 2000;
  localparam int HPD_CYCLES = HPD_TIME_MS * CLK_MHZ * 1000;
  localparam int HPD_W = 29;
  localparam logic [7:0] EXT_COUNT_ADDR = 8'h7e;
  localparam logic [7:0] LAST_ADDR = 8'hff;
  localparam logic [7:0] FILL_BYTE = 8'hff;
  localparam logic [7:0] NO_EXT_BYTE = 8'h00;
  localparam logic [NUM_IN-1:0] PEND_RST = 4'h0;
  localparam logic [NUM_OUT-1:0] CAP_RST = 2'h0;

  typedef enum logic [0:0] {
    CP_IDLE = 1'b0,
    CP_RUN = 1'b1
  } edr_cp_e;

  // Factory slot contents: fixed header in the base block, a slot-specific pattern elsewhere
  function automatic logic [7:0] edr_fac_byte(input logic sel, input logic [7:0] a);
    if (a < 8'h08) begin
      return (a == 8'h00 || a == 8'h07) ? 8'h00 : 8'hff;
    end
    return {sel, a[6:0]} ^ 8'h5a;
  endfunction
endpackage

//--- edr_router.sv
// Per-input display-identification emulation router with slot store and sink capture
//
// Function
// - Each input has its own emulation memory, and loading one input never alters another.
// - After the data of an input changes, its sink_attach_line is pulled low for 2 seconds.
// - Data captured from each output's sink is kept and stays available after the sink leaves.
// - The store holds factory sets and user-writable sets, any of which can feed any input.
// - Static emulation copies the selected store slot into the input's emulation memory.
// - Dynamic emulation copies an output's captured data and recopies when a new valid capture lands.
// - Every emulated set has a 128-byte base block.
// - An optional 128-byte extended_display_block follows the base block.
// - Data on an input may be replaced at any time while a source stays connected.
`timescale 1ns/1ps
`default_nettype none
module edr_router
  import edr_pkg::*;
#(
  parameter int HPD_CYCLES_P = HPD_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // User slot write
  input wire logic slot_wr_valid,
  input wire logic slot_wr_idx,
  input wire logic [7:0] slot_wr_addr,
  input wire logic [7:0] slot_wr_data,
  // Sink capture from the outputs
  input wire logic cap_valid,
  input wire logic cap_out,
  input wire logic [7:0] cap_addr,
  input wire logic [7:0] cap_data,
  input wire logic cap_done,
  input wire logic cap_good,
  // Input configuration
  input wire logic cfg_valid,
  input wire logic [IN_W-1:0] cfg_in,
  input wire logic cfg_dynamic,
  input wire logic [SRC_W-1:0] cfg_src,
  input wire logic cfg_ext_en,
  // Source-side DDC read ports
  input wire logic [NUM_IN-1:0][7:0] ddc_addr,
  output logic [NUM_IN-1:0][7:0] ddc_data,
  // Status
  output logic [NUM_IN-1:0] sink_attach_line,
  output logic [NUM_OUT-1:0] cap_present,
  output logic busy
);

  logic [7:0] user_mem [NUM_USER][EMU_BYTES];
  logic [7:0] cap_mem [NUM_OUT][EMU_BYTES];
  logic [7:0] emu_mem [NUM_IN][EMU_BYTES];

  logic [NUM_IN-1:0] dyn_reg, dyn_next, ext_reg, ext_next, emu_ext_reg, emu_ext_next;
  logic [NUM_IN-1:0][SRC_W-1:0] src_reg, src_next;
  logic [NUM_IN-1:0] pend_reg, pend_next, pend_set, pend_clr;
  logic [NUM_OUT-1:0] cap_present_reg, cap_present_next;
  logic [NUM_IN-1:0][HPD_W-1:0] hpd_cnt_reg, hpd_cnt_next;
  logic [NUM_IN-1:0][7:0] ddc_data_reg, ddc_data_next;
  edr_cp_e cp_state_reg, cp_state_next;
  logic [IN_W-1:0] cin_reg, cin_next, pick;
  logic [7:0] cnt_reg, cnt_next, cp_byte;
  logic pick_any, cur_dyn, cp_fin, skip;
  logic [SRC_W-1:0] cur_src;
  logic [HPD_W-1:0] hpd_load;

  assign hpd_load = HPD_W'(HPD_CYCLES_P);
  assign cur_dyn = dyn_reg[cin_reg];
  assign cur_src = src_reg[cin_reg];
  assign cp_fin = (cp_state_reg == CP_RUN) && (cnt_reg == LAST_ADDR);

  // Byte fed to the emulation memory by the copier
  always_comb begin
    if (cur_dyn) begin
      cp_byte = cap_mem[cur_src[0]][cnt_reg];
    end else if (cur_src < SRC_W'(NUM_FAC)) begin
      cp_byte = edr_fac_byte(cur_src[0], cnt_reg);
    end else begin
      cp_byte = user_mem[cur_src[0]][cnt_reg];
    end
  end

  // Storage: slots, captures and per-input emulation, not cleared by reset
  always_ff @(posedge mclk) begin
    if (slot_wr_valid) begin
      user_mem[slot_wr_idx][slot_wr_addr] <= slot_wr_data;
    end
    if (cap_valid) begin
      cap_mem[cap_out][cap_addr] <= cap_data;
    end
    if (cp_state_reg == CP_RUN) begin
      emu_mem[cin_reg][cnt_reg] <= cp_byte;
    end
  end

  // Configuration, capture flags and pending copy requests
  always_comb begin
    dyn_next = dyn_reg;
    src_next = src_reg;
    ext_next = ext_reg;
    pend_set = '0;
    cap_present_next = cap_present_reg;
    if (cfg_valid) begin
      dyn_next[cfg_in] = cfg_dynamic;
      src_next[cfg_in] = cfg_src;
      ext_next[cfg_in] = cfg_ext_en;
      pend_set[cfg_in] = 1'b1;
    end
    if (cap_done && cap_good) begin
      cap_present_next[cap_out] = 1'b1;
      for (int i = 0; i < NUM_IN; i++) begin
        if (dyn_reg[i] && (src_reg[i][0] == cap_out)) begin
          pend_set[i] = 1'b1;
        end
      end
    end
    pend_next = (pend_reg & ~pend_clr) | pend_set;
  end

  // Copier: picks the lowest pending input and copies all bytes, or drops it unqueued if it is dynamic and its output has no capture
  always_comb begin
    pick = '0;
    pick_any = 1'b0;
    for (int i = NUM_IN - 1; i >= 0; i--) begin
      if (pend_reg[i]) begin
        pick = IN_W'(i);
        pick_any = 1'b1;
      end
    end
    skip = dyn_reg[pick] && !cap_present_reg[src_reg[pick][0]];
    cp_state_next = cp_state_reg;
    cin_next = cin_reg;
    cnt_next = cnt_reg;
    pend_clr = '0;
    emu_ext_next = emu_ext_reg;
    unique case (cp_state_reg)
      CP_IDLE: begin
        if (pick_any) begin
          pend_clr[pick] = 1'b1;
          if (!skip) begin
            cp_state_next = CP_RUN;
            cin_next = pick;
            cnt_next = '0;
          end
        end
      end
      CP_RUN: begin
        cnt_next = cnt_reg + 8'h01;
        if (cp_fin) begin
          cp_state_next = CP_IDLE;
          emu_ext_next[cin_reg] = ext_reg[cin_reg];
        end
      end
    endcase
  end

  // Attach line timers and registered DDC read data
  always_comb begin
    for (int i = 0; i < NUM_IN; i++) begin
      hpd_cnt_next[i] = (hpd_cnt_reg[i] != '0) ? hpd_cnt_reg[i] - 1'b1 : hpd_cnt_reg[i];
      if (cp_fin && (cin_reg == IN_W'(i))) begin
        hpd_cnt_next[i] = hpd_load;
      end
      if (ddc_addr[i][7] && !emu_ext_reg[i]) begin
        ddc_data_next[i] = FILL_BYTE;
      end else if ((ddc_addr[i] == EXT_COUNT_ADDR) && !emu_ext_reg[i]) begin
        ddc_data_next[i] = NO_EXT_BYTE;
      end else begin
        ddc_data_next[i] = emu_mem[i][ddc_addr[i]];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      dyn_reg <= '0;
      src_reg <= '0;
      ext_reg <= '0;
      emu_ext_reg <= '0;
      pend_reg <= PEND_RST;
      cap_present_reg <= CAP_RST;
      hpd_cnt_reg <= '0;
      ddc_data_reg <= '0;
      cp_state_reg <= CP_IDLE;
      cin_reg <= '0;
      cnt_reg <= '0;
    end else begin
      dyn_reg <= dyn_next;
      src_reg <= src_next;
      ext_reg <= ext_next;
      emu_ext_reg <= emu_ext_next;
      pend_reg <= pend_next;
      cap_present_reg <= cap_present_next;
      hpd_cnt_reg <= hpd_cnt_next;
      ddc_data_reg <= ddc_data_next;
      cp_state_reg <= cp_state_next;
      cin_reg <= cin_next;
      cnt_reg <= cnt_next;
    end
  end

  always_comb begin
    for (int i = 0; i < NUM_IN; i++) begin
      sink_attach_line[i] = (hpd_cnt_reg[i] == '0);
    end
  end
  assign ddc_data = ddc_data_reg;
  assign cap_present = cap_present_reg;
  assign busy = (cp_state_reg == CP_RUN) || (pend_reg != '0);

  // Checking helpers
  logic [8:0] run_len;
  logic [HPD_W-1:0] low_run;
  always_ff @(posedge mclk) begin
    if (reset) begin
      run_len <= '0;
      low_run <= '0;
    end else begin
      run_len <= (cp_state_reg == CP_RUN) ? run_len + 9'h001 : 9'h000;
      low_run <= sink_attach_line[0] ? '0 : low_run + 1'b1;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  sequence copy_start_s;
    (cp_state_reg == CP_IDLE) ##1 (cp_state_reg == CP_RUN);
  endsequence
  sequence copy_body_s;
    (cp_state_reg == CP_RUN) [*8];
  endsequence

  chk_copy_body: assert property (copy_start_s |-> copy_body_s)
    else $error("copy ended early");
  chk_copy_len: assert property ($fell(cp_state_reg == CP_RUN) |-> run_len == 9'h100)
    else $error("copy did not move 256 bytes");
  chk_hpd_start: assert property (cp_fin && cin_reg == 2'd0 |=> !sink_attach_line[0] ##1 !sink_attach_line[0])
    else $error("attach line not pulled after change");
  chk_hpd_len: assert property ($rose(sink_attach_line[0]) |-> low_run >= hpd_load)
    else $error("attach line pulse too short");
  chk_other_hold: assert property (cp_state_reg == CP_RUN && cin_reg != 2'd0 |=> $stable(emu_mem[0][0]))
    else $error("foreign input data changed");
  chk_emu_write: assert property (cp_state_reg == CP_RUN && cnt_reg == 8'h00 |=> emu_mem[$past(cin_reg)][0] == $past(cp_byte))
    else $error("emulation byte not copied");
  chk_ext_fill: assert property (ddc_addr[0][7] && !emu_ext_reg[0] && !cp_fin |=> ddc_data[0] == FILL_BYTE)
    else $error("absent extension not filled");
  chk_ext_count: assert property (ddc_addr[0] == EXT_COUNT_ADDR && !emu_ext_reg[0] && !cp_fin |=> ddc_data[0] == NO_EXT_BYTE)
    else $error("extension count not cleared");
  chk_dyn_pend: assert property (cap_done && cap_good && dyn_reg[0] && src_reg[0][0] == cap_out |=> pend_reg[0])
    else $error("dynamic input not refreshed");
  chk_cap_keep: assert property (!$fell(cap_present_reg[0]))
    else $error("captured data lost");
  chk_cfg_pend: assert property (cfg_valid |=> pend_reg[$past(cfg_in)])
    else $error("configuration change not queued");
endmodule
`default_nettype wire

//--- edr_src_model.sv
// Video source model reading identification bytes over each input's DDC lane
`timescale 1ns/1ps
`default_nettype none
module edr_src_model
  import edr_pkg::*;
(
  // Clock
  input wire logic mclk,
  // DDC lanes
  output logic [NUM_IN-1:0][7:0] ddc_addr,
  input wire logic [NUM_IN-1:0][7:0] ddc_data
);
  initial ddc_addr = '0;

  // Address set after a falling edge, byte taken one falling edge later
  task automatic rd(input int i, input logic [7:0] a, output logic [7:0] d);
    @(negedge mclk);
    ddc_addr[i] = a;
    @(posedge mclk);
    @(negedge mclk);
    d = ddc_data[i];
    ddc_addr[i] = ~a;
  endtask
endmodule
`default_nettype wire

//--- tb_edr_router.sv
// Self-checking testbench for the emulation router
`timescale 1ns/1ps
`default_nettype none
module tb_edr_router;
  import edr_pkg::*;
  localparam int HP = 20;
  logic mclk, reset, slot_wr_valid, slot_wr_idx, cap_valid, cap_out, cap_done, cap_good;
  logic cfg_valid, cfg_dynamic, cfg_ext_en, busy;
  logic [7:0] slot_wr_addr, slot_wr_data, cap_addr, cap_data;
  logic [IN_W-1:0] cfg_in;
  logic [SRC_W-1:0] cfg_src;
  logic [NUM_IN-1:0][7:0] ddc_addr, ddc_data;
  logic [NUM_IN-1:0] sink_attach_line;
  logic [NUM_OUT-1:0] cap_present;
  int n_mismatch, checks, cyc;

  edr_router #(.HPD_CYCLES_P(HP)) edr_router_inst (.mclk(mclk), .reset(reset),
    .slot_wr_valid(slot_wr_valid), .slot_wr_idx(slot_wr_idx), .slot_wr_addr(slot_wr_addr),
    .slot_wr_data(slot_wr_data), .cap_valid(cap_valid), .cap_out(cap_out), .cap_addr(cap_addr),
    .cap_data(cap_data), .cap_done(cap_done), .cap_good(cap_good), .cfg_valid(cfg_valid),
    .cfg_in(cfg_in), .cfg_dynamic(cfg_dynamic), .cfg_src(cfg_src), .cfg_ext_en(cfg_ext_en),
    .ddc_addr(ddc_addr), .ddc_data(ddc_data), .sink_attach_line(sink_attach_line),
    .cap_present(cap_present), .busy(busy));
  edr_src_model edr_src_model_inst (.mclk(mclk), .ddc_addr(ddc_addr), .ddc_data(ddc_data));

  initial mclk = 1'b0;
  always #2 mclk = ~mclk;

  task automatic test_done();
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      test_done();
    end
  end

  task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic rd_chk(input int i, input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    edr_src_model_inst.rd(i, a, d);
    cmp("ddc byte", e, d);
  endtask

  // Waits for the copier, then measures how long the attach line stays low
  task automatic settle(input int i, input int exp_low);
    int n;
    n = 0;
    @(negedge mclk);
    while (busy !== 1'b0 && n < 600) begin
      n++;
      @(negedge mclk);
    end
    cmp("busy", 8'h00, {7'h0, busy});
    n = 0;
    while (sink_attach_line[i] === 1'b0 && n < 100) begin
      n++;
      @(negedge mclk);
    end
    cmp("attach low cycles", exp_low[7:0], n[7:0]);
  endtask

  task automatic cfg(input int i, input logic dyn, input logic [1:0] s, input logic ext, input int lo);
    @(negedge mclk);
    cfg_valid = 1'b1;
    cfg_in = i[1:0];
    cfg_dynamic = dyn;
    cfg_src = s;
    cfg_ext_en = ext;
    @(negedge mclk);
    cfg_valid = 1'b0;
    settle(i, lo);
  endtask

  task automatic cap(input logic o, input logic [7:0] x, input logic g);
    for (int a = 0; a < 256; a++) begin
      @(negedge mclk);
      cap_valid = 1'b1;
      cap_out = o;
      cap_addr = a[7:0];
      cap_data = a[7:0] ^ x;
    end
    @(negedge mclk);
    cap_valid = 1'b0;
    cap_done = 1'b1;
    cap_good = g;
    @(negedge mclk);
    cap_done = 1'b0;
  endtask

  task automatic wr(input logic s, input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    slot_wr_valid = 1'b1;
    slot_wr_idx = s;
    slot_wr_addr = a;
    slot_wr_data = d;
    @(negedge mclk);
    slot_wr_valid = 1'b0;
  endtask

  task automatic t_reset();
    cmp("attach", 8'h0f, {4'h0, sink_attach_line});
    cmp("cap_present", 8'h00, {6'h0, cap_present});
    rd_chk(0, 8'h80, 8'hff);
    rd_chk(0, 8'h7e, 8'h00);
  endtask

  // Input 0 is loaded first so its emulation bytes are defined before other inputs copy
  task automatic t_static();
    cfg(0, 1'b0, 2'h0, 1'b1, HP);
    rd_chk(0, 8'h20, 8'h7a);
    cfg(1, 1'b0, 2'h1, 1'b1, HP);
    cmp("other attach", 8'h01, {7'h0, sink_attach_line[0]});
    rd_chk(1, 8'h00, 8'h00);
    rd_chk(1, 8'h03, 8'hff);
    rd_chk(1, 8'h10, 8'hca);
    rd_chk(1, 8'h85, 8'hdf);
  endtask

  task automatic t_user();
    wr(1'b0, 8'h00, 8'h12);
    wr(1'b1, 8'h00, 8'h34);
    wr(1'b0, 8'h05, 8'ha5);
    wr(1'b0, 8'h81, 8'h3c);
    wr(1'b1, 8'h05, 8'h5c);
    cfg(2, 1'b0, 2'h2, 1'b0, HP);
    rd_chk(2, 8'h05, 8'ha5);
    rd_chk(2, 8'h00, 8'h12);
    rd_chk(2, 8'h81, 8'hff);
    rd_chk(2, 8'h7e, 8'h00);
    cfg(2, 1'b0, 2'h3, 1'b1, HP);
    rd_chk(2, 8'h05, 8'h5c);
    rd_chk(2, 8'h00, 8'h34);
    rd_chk(1, 8'h10, 8'hca);
  endtask

  task automatic t_capture();
    cap(1'b0, 8'h11, 1'b0);
    cmp("cap_present", 8'h00, {6'h0, cap_present});
    cfg(0, 1'b1, 2'h0, 1'b1, 0);
    rd_chk(0, 8'h20, 8'h7a);
    cap(1'b1, 8'h33, 1'b1);
    cmp("cap_present", 8'h02, {6'h0, cap_present});
    cfg(3, 1'b1, 2'h1, 1'b1, HP);
    rd_chk(3, 8'h40, 8'h73);
    rd_chk(3, 8'hc0, 8'hf3);
    cap(1'b1, 8'hc3, 1'b1);
    settle(3, HP);
    rd_chk(3, 8'h40, 8'h83);
    rd_chk(2, 8'h05, 8'h5c);
    cap(1'b0, 8'h5a, 1'b1);
    cmp("cap_present", 8'h03, {6'h0, cap_present});
    settle(0, HP);
    rd_chk(0, 8'h40, 8'h1a);
  endtask

  initial begin
    {reset, slot_wr_valid, slot_wr_idx, cap_valid, cap_out, cap_done, cap_good} = 7'h01 << 6;
    {cfg_valid, cfg_dynamic, cfg_ext_en, cfg_in, cfg_src} = 7'h00;
    {slot_wr_addr, slot_wr_data, cap_addr, cap_data} = 32'h0;
    n_mismatch = 0;
    checks = 0;
    repeat (3) @(negedge mclk);
    reset = 1'b0;
    t_reset();
    t_static();
    t_user();
    t_capture();
    test_done();
  end
endmodule
`default_nettype wire
